/* pkg/cap_pkg.sv */
// Package: register map, field layout and timing constants for the pop/tie-off/irq bank
package cap_pkg;

    // ----------------------------------------------------------------
    // Register offsets (word addresses on the control interface)
    // ----------------------------------------------------------------
    localparam logic [7:0] POWER_MANAGEMENT_ONE_ADDR      = 8'h08;
    localparam logic [7:0] COMPARATOR_IRQ_STATUS_ADDR     = 8'h1F;
    localparam logic [7:0] COMPARATOR_IRQ_MASK_ADDR       = 8'h27;
    localparam logic [7:0] OUTPUT_TIEOFF_CONTROL_ADDR     = 8'h4C;
    localparam logic [7:0] POP_AND_DISCHARGE_CONTROL_ADDR = 8'h4E;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TIEOFF_BUFFER_FORCE_BIT   = 13;
    localparam int TIEOFF_RES_LSB            = 8;
    localparam int RAMP_SPEED_LSB            = 8;
    localparam int OUT_FOUR_DISCHARGE_LSB    = 6;
    localparam int OUT_THREE_DISCHARGE_LSB   = 4;
    localparam int PAIR_TWO_DISCHARGE_LSB    = 2;
    localparam int PAIR_ONE_DISCHARGE_LSB    = 0;
    localparam int EVENT_LSB                 = 8;
    localparam int LEFT_JACK_EVENT_BIT       = 11;
    localparam int RIGHT_JACK_EVENT_BIT      = 10;
    localparam int MIC_SHORT_EVENT_BIT       = 9;
    localparam int MIC_PRESENT_EVENT_BIT     = 8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic       TIEOFF_BUFFER_FORCE_RST = 1'b0;
    localparam logic [3:0] TIEOFF_RES_RST          = 4'h0;
    localparam logic [9:0] POP_DISCHARGE_RST       = 10'h000;
    localparam logic [3:0] EVENT_MASK_RST          = 4'h0;
    localparam logic [3:0] EVENT_STATUS_RST        = 4'h0;

    // ----------------------------------------------------------------
    // Rate codes shared by ramp and discharge fields
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CAP_RATE_OFF     = 2'h0,
        CAP_RATE_FAST    = 2'h1,
        CAP_RATE_MEDIUM  = 2'h2,
        CAP_RATE_SLOW    = 2'h3
    } cap_rate_t;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ       = 125_000_000;
    localparam int SLOW_CLK_HZ       = 1_000;
    localparam int SLOW_DIV_CYCLES   = CLK_FREQ_HZ / SLOW_CLK_HZ;
    localparam int ZC_TIMEOUT_TICKS  = 64;

endpackage : cap_pkg

/* design/cap_bank.sv */
// Design: anti-pop, discharge, tie-off, zero-cross timeout and codec event bank
`timescale 1ns/1ps

module cap_bank #(
    parameter int N_PGA          = 4,
    parameter int SLOW_DIV       = cap_pkg::SLOW_DIV_CYCLES,
    parameter int ZC_TIMEOUT     = cap_pkg::ZC_TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [15:0]       reg_wdata,
    output logic      [15:0]       reg_rdata,
    output logic                   reg_rvalid,
    // Comparator conditions
    input  wire logic              left_jack_level,
    input  wire logic              right_jack_level,
    input  wire logic              mic_over_short_threshold,
    input  wire logic              mic_over_detect_threshold,
    // Output enables from the path controls
    input  wire logic [3:0]        out_enable,
    // Slow clock gate and gain stages
    input  wire logic              slow_clock_on,
    input  wire logic [N_PGA-1:0]  zc_enable,
    input  wire logic [N_PGA-1:0]  gain_pending,
    input  wire logic [N_PGA-1:0]  zero_cross,
    output logic      [N_PGA-1:0]  gain_apply,
    // Analogue controls
    output logic      [1:0]        ramp_speed,
    output logic      [1:0]        out_four_discharge_rate,
    output logic      [1:0]        out_three_discharge_rate,
    output logic      [1:0]        pair_two_discharge_rate,
    output logic      [1:0]        pair_one_discharge_rate,
    output logic                   tieoff_buffer_force,
    output logic      [3:0]        tieoff_low_res_on,
    output logic      [3:0]        tieoff_high_res_on,
    // Interrupt
    output logic                   codec_first_level_irq
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic                   buffer_force;
    logic [3:0]             tieoff_resistance_select;
    logic [9:0]             pop_discharge;
    logic [3:0]             event_mask_prefix;
    logic [3:0]             event_status;
    logic [3:0]             cmp_prev;
    logic                   cmp_primed;
    logic [3:0]             cmp_now;
    logic [3:0]             cmp_edge;
    logic [3:0]             read_clear;
    logic [3:0]             next_status;
    logic [15:0]            next_rdata;
    logic                   wr_pm1;
    logic                   wr_mask;
    logic                   wr_tie;
    logic                   wr_pop;
    logic                   rd_status;

    // Width-safe equality on the 8-bit address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    assign wr_pm1    = reg_wr && hit(reg_addr, cap_pkg::POWER_MANAGEMENT_ONE_ADDR);
    assign wr_mask   = reg_wr && hit(reg_addr, cap_pkg::COMPARATOR_IRQ_MASK_ADDR);
    assign wr_tie    = reg_wr && hit(reg_addr, cap_pkg::OUTPUT_TIEOFF_CONTROL_ADDR);
    assign wr_pop    = reg_wr && hit(reg_addr, cap_pkg::POP_AND_DISCHARGE_CONTROL_ADDR);
    assign rd_status = reg_rd && hit(reg_addr, cap_pkg::COMPARATOR_IRQ_STATUS_ADDR);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Only the force bit of this power register lives in this bank
    always_ff @(posedge clk) begin
        if (rst) begin
            buffer_force <= cap_pkg::TIEOFF_BUFFER_FORCE_RST;
        end else if (wr_pm1) begin
            buffer_force <= reg_wdata[cap_pkg::TIEOFF_BUFFER_FORCE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tieoff_resistance_select <= cap_pkg::TIEOFF_RES_RST;
        end else if (wr_tie) begin
            tieoff_resistance_select <= reg_wdata[cap_pkg::TIEOFF_RES_LSB +: 4];
        end
    end

    // Ramp and all four discharge codes share one register
    always_ff @(posedge clk) begin
        if (rst) begin
            pop_discharge <= cap_pkg::POP_DISCHARGE_RST;
        end else if (wr_pop) begin
            pop_discharge <= reg_wdata[9:0];
        end
    end

    // Mask gates only the interrupt pin; status still records every edge
    always_ff @(posedge clk) begin
        if (rst) begin
            event_mask_prefix <= cap_pkg::EVENT_MASK_RST;
        end else if (wr_mask) begin
            event_mask_prefix <= reg_wdata[cap_pkg::EVENT_LSB +: 4];
        end
    end

    // ----------------------------------------------------------------
    // Analogue control outputs
    // ----------------------------------------------------------------
    // Codes pass straight through; code 00 leaves a ramp or discharge path off
    always_ff @(posedge clk) begin
        if (rst) begin
            ramp_speed <= cap_pkg::CAP_RATE_OFF;
        end else begin
            ramp_speed <= pop_discharge[cap_pkg::RAMP_SPEED_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_four_discharge_rate <= cap_pkg::CAP_RATE_OFF;
        end else begin
            out_four_discharge_rate <= pop_discharge[cap_pkg::OUT_FOUR_DISCHARGE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_three_discharge_rate <= cap_pkg::CAP_RATE_OFF;
        end else begin
            out_three_discharge_rate <= pop_discharge[cap_pkg::OUT_THREE_DISCHARGE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pair_two_discharge_rate <= cap_pkg::CAP_RATE_OFF;
        end else begin
            pair_two_discharge_rate <= pop_discharge[cap_pkg::PAIR_TWO_DISCHARGE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pair_one_discharge_rate <= cap_pkg::CAP_RATE_OFF;
        end else begin
            pair_one_discharge_rate <= pop_discharge[cap_pkg::PAIR_ONE_DISCHARGE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tieoff_buffer_force <= cap_pkg::TIEOFF_BUFFER_FORCE_RST;
        end else begin
            tieoff_buffer_force <= buffer_force;
        end
    end

    // Enabled outputs drop both tie-offs; the select bit is then don't-care
    always_ff @(posedge clk) begin
        if (rst) begin
            tieoff_low_res_on <= 4'h0;
        end else begin
            tieoff_low_res_on <= ~out_enable & ~tieoff_resistance_select;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tieoff_high_res_on <= 4'h0;
        end else begin
            tieoff_high_res_on <= ~out_enable & tieoff_resistance_select;
        end
    end

    // ----------------------------------------------------------------
    // Comparator event capture
    // ----------------------------------------------------------------
    // Mic inputs are the bias-current comparisons against the two thresholds
    assign cmp_now[cap_pkg::LEFT_JACK_EVENT_BIT - cap_pkg::EVENT_LSB]   = left_jack_level;
    assign cmp_now[cap_pkg::RIGHT_JACK_EVENT_BIT - cap_pkg::EVENT_LSB]  = right_jack_level;
    assign cmp_now[cap_pkg::MIC_SHORT_EVENT_BIT - cap_pkg::EVENT_LSB]   = mic_over_short_threshold;
    assign cmp_now[cap_pkg::MIC_PRESENT_EVENT_BIT - cap_pkg::EVENT_LSB] = mic_over_detect_threshold;

    // First cycle after reset only primes the history, so a level already
    // high at release is not mistaken for an edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_prev <= 4'h0;
        end else begin
            cmp_prev <= cmp_now;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_primed <= 1'b0;
        end else begin
            cmp_primed <= 1'b1;
        end
    end

    assign cmp_edge   = cmp_primed ? (cmp_now ^ cmp_prev) : 4'h0;
    assign read_clear = rd_status ? event_status : 4'h0;

    // New edge in the read cycle survives the clear
    always_comb begin
        next_status = (event_status & ~read_clear) | cmp_edge;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            event_status <= cap_pkg::EVENT_STATUS_RST;
        end else begin
            event_status <= next_status;
        end
    end

    // Lags status by one cycle so the pin comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            codec_first_level_irq <= 1'b0;
        end else begin
            codec_first_level_irq <= |(event_status & ~event_mask_prefix);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 16'h0000;
        unique case (reg_addr)
            cap_pkg::POWER_MANAGEMENT_ONE_ADDR:
                next_rdata[cap_pkg::TIEOFF_BUFFER_FORCE_BIT] = buffer_force;
            cap_pkg::COMPARATOR_IRQ_STATUS_ADDR:
                next_rdata[cap_pkg::EVENT_LSB +: 4] = event_status;
            cap_pkg::COMPARATOR_IRQ_MASK_ADDR:
                next_rdata[cap_pkg::EVENT_LSB +: 4] = event_mask_prefix;
            cap_pkg::OUTPUT_TIEOFF_CONTROL_ADDR:
                next_rdata[cap_pkg::TIEOFF_RES_LSB +: 4] = tieoff_resistance_select;
            cap_pkg::POP_AND_DISCHARGE_CONTROL_ADDR:
                next_rdata[9:0] = pop_discharge;
            default:
                next_rdata = 16'h0000;
        endcase
    end

    // Unmapped addresses still answer, with zeros, so the host never stalls
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // Read data holds between reads; only rvalid marks a fresh word
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Slow clock tick
    // ----------------------------------------------------------------
    // Held at zero while the slow clock is off, so timeouts stall too
    logic [$clog2(SLOW_DIV+1)-1:0] slow_cnt;
    logic                          slow_tick;

    always_ff @(posedge clk) begin
        if (rst || !slow_clock_on) begin
            slow_cnt  <= '0;
            slow_tick <= 1'b0;
        end else if (slow_cnt == $bits(slow_cnt)'(SLOW_DIV - 1)) begin
            slow_cnt  <= '0;
            slow_tick <= 1'b1;
        end else begin
            slow_cnt  <= slow_cnt + 1'b1;
            slow_tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Zero-cross timeout per gain stage
    // ----------------------------------------------------------------
    // A pending change applies at a crossing, at timeout, or at once when
    // zero-cross updating is off for that stage.
    logic [$clog2(ZC_TIMEOUT+1)-1:0] zc_cnt [N_PGA];

    always_ff @(posedge clk) begin
        if (rst) begin
            gain_apply <= '0;
            for (int i = 0; i < N_PGA; i++) begin
                zc_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N_PGA; i++) begin
                gain_apply[i] <= 1'b0;
                if (!gain_pending[i] || gain_apply[i]) begin
                    zc_cnt[i] <= '0;
                end else if (!zc_enable[i] || zero_cross[i]) begin
                    gain_apply[i] <= 1'b1;
                    zc_cnt[i]     <= '0;
                end else if (zc_cnt[i] == $bits(zc_cnt[i])'(ZC_TIMEOUT)) begin
                    gain_apply[i] <= 1'b1;
                    zc_cnt[i]     <= '0;
                end else if (slow_tick) begin
                    zc_cnt[i] <= zc_cnt[i] + 1'b1;
                end
            end
        end
    end

endmodule : cap_bank

/* dv/cap_bank_props.sv */
// Checker: port-level properties of the pop, tie-off and codec event bank
`timescale 1ns/1ps

module cap_bank_props #(
    parameter int N_PGA      = 4,
    parameter int SLOW_DIV   = 4,
    parameter int ZC_TIMEOUT = 3
) (
    // Inputs of the bank
    input wire logic             clk,
    input wire logic             rst,
    input wire logic [7:0]       reg_addr,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [15:0]      reg_wdata,
    input wire logic             left_jack_level,
    input wire logic             right_jack_level,
    input wire logic             mic_over_short_threshold,
    input wire logic             mic_over_detect_threshold,
    input wire logic [3:0]       out_enable,
    input wire logic             slow_clock_on,
    input wire logic [N_PGA-1:0] zc_enable,
    input wire logic [N_PGA-1:0] gain_pending,
    input wire logic [N_PGA-1:0] zero_cross,
    // Outputs of the bank
    input wire logic             reg_rvalid,
    input wire logic [N_PGA-1:0] gain_apply,
    input wire logic             tieoff_buffer_force,
    input wire logic [3:0]       tieoff_low_res_on,
    input wire logic [3:0]       tieoff_high_res_on,
    input wire logic             codec_first_level_irq
);
    // Slack of a few cycles for tick phase at the start of a wait
    localparam int ZC_BOUND = SLOW_DIV * (ZC_TIMEOUT + 1) + 4;
    logic [3:0]       lvl, lvl_q, mask_sh, sel_sh;
    logic [N_PGA-1:0] imm;
    logic             moved, rd_stat, wr_mask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    assign lvl = {left_jack_level, right_jack_level, mic_over_short_threshold, mic_over_detect_threshold};
    assign moved = (lvl != lvl_q);
    assign rd_stat = reg_rd && (reg_addr == 8'h1F);
    assign wr_mask = reg_wr && (reg_addr == 8'h27);
    assign imm = gain_pending & (~zc_enable | zero_cross) & ~gain_apply;

    // Shadows of mask and select, so irq and tie-off can be judged
    always_ff @(posedge clk) begin
        lvl_q <= lvl;
        if (rst) begin
            mask_sh <= 4'h0;
            sel_sh  <= 4'h0;
        end else begin
            if (wr_mask) mask_sh <= reg_wdata[11:8];
            if (reg_wr && reg_addr == 8'h4C) sel_sh <= reg_wdata[11:8];
        end
    end

    sequence s_quiet_read;
        (!moved)[*3] ##0 rd_stat ##1 (!moved)[*2];
    endsequence
    sequence s_open_edge;
        // The first cycle after reset only primes the edge history
        !$past(rst) && (((lvl ^ lvl_q) & ~mask_sh) != 4'h0) && !wr_mask ##1 !wr_mask;
    endsequence

    AST_RVALID_AFTER_READ: assert property (##1 reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    AST_READ_CLEARS_IRQ: assert property (s_quiet_read |=> !codec_first_level_irq)
        else $error("status read did not clear the interrupt");
    AST_EDGE_RAISES_IRQ: assert property (s_open_edge |=> ##[0:1] codec_first_level_irq)
        else $error("unmasked comparator edge gave no interrupt");
    AST_MASK_BLOCKS_IRQ: assert property ((mask_sh == 4'hF)[*2] |-> !codec_first_level_irq)
        else $error("interrupt seen with all sources masked");
    AST_FORCE_FOLLOWS: assert property (reg_wr && reg_addr == 8'h08 |=> ##1
        tieoff_buffer_force == $past(reg_wdata[13], 2))
        else $error("tie-off force does not follow its bit");
    AST_TIEOFF_SELECT: assert property (($stable(out_enable) && $stable(sel_sh))[*2] |->
        tieoff_low_res_on == (~out_enable & ~sel_sh) && tieoff_high_res_on == (~out_enable & sel_sh))
        else $error("tie-off resistance wrong for enable and select");
    AST_ZC_IMMEDIATE: assert property (imm != '0 |=> (gain_apply & $past(imm)) == $past(imm))
        else $error("gain not applied on crossing or without zero-cross");
    AST_ZC_TIMEOUT: assert property (gain_pending[0] && zc_enable[0] && slow_clock_on |->
        ##[0:ZC_BOUND] (gain_apply[0] || !gain_pending[0] || !slow_clock_on))
        else $error("zero-cross timeout did not apply the gain");
endmodule : cap_bank_props

bind cap_bank cap_bank_props #(.N_PGA(N_PGA), .SLOW_DIV(SLOW_DIV), .ZC_TIMEOUT(ZC_TIMEOUT)) u_props (.*);

/* dv/cap_host_model.sv */
// Partner: host software on the register strobe port
`timescale 1ns/1ps

module cap_host_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    // Slow clock gate
    output logic             slow_clock_on
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        slow_clock_on = 1'b1;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // Stale data would hide a write taken a cycle late
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        ok = reg_rvalid;
    endtask : rd

    task automatic slow_gate(input logic on);
        @(negedge clk);
        slow_clock_on = on;
    endtask : slow_gate
endmodule : cap_host_model

/* dv/tb_cap_bank.sv */
// Testbench: self-checking scenarios for the pop, tie-off and codec event bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb_cap_bank;
    localparam int SLOW_DIV = 4;
    localparam int ZC_TIMEOUT = 3;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr;
    logic        reg_wr, reg_rd, reg_rvalid, slow_clock_on, tieoff_buffer_force, codec_first_level_irq, ok;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [3:0]  lv = 4'h0;
    logic [3:0]  out_enable = 4'h3;
    logic [3:0]  zc_enable = 4'h0;
    logic [3:0]  gain_pending = 4'h0;
    logic [3:0]  zero_cross = 4'h0;
    logic [3:0]  gain_apply, tieoff_low_res_on, tieoff_high_res_on, ap;
    logic [1:0]  ramp_speed, out_four_discharge_rate, out_three_discharge_rate;
    logic [1:0]  pair_two_discharge_rate, pair_one_discharge_rate;
    logic        left_jack_level, right_jack_level, mic_over_short_threshold, mic_over_detect_threshold;
    int          n_errors = 0;
    int          num_checks = 0;

    assign {left_jack_level, right_jack_level, mic_over_short_threshold, mic_over_detect_threshold} = lv;
    always #4 clk = ~clk;
    cap_bank #(.N_PGA(4), .SLOW_DIV(SLOW_DIV), .ZC_TIMEOUT(ZC_TIMEOUT)) uut (.*);
    cap_host_model host (.*);

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, e)
    endtask : rchk

    // Waits for an apply pulse on stage 0; pending drops only once applied
    task automatic wait_apply(input int lim, output int n);
        n = 0;
        while (gain_apply[0] !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        ap = gain_apply;
        if (n < lim) gain_pending = 4'h0;
    endtask : wait_apply

    task automatic t_reset;
        rchk(8'h27, 16'h0000);
        rchk(8'h4E, 16'h0000);
        rchk(8'h4C, 16'h0000);
        rchk(8'h08, 16'h0000);
        host.wr(8'h1F, 16'hFFFF);
        rchk(8'h1F, 16'h0000);
        rchk(8'h00, 16'h0000);
        `CHK(tieoff_low_res_on, 4'hC)
    endtask : t_reset

    task automatic t_pop_and_force;
        logic [1:0] k;
        logic [9:0] v;
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            v = {k, k + 2'h1, k + 2'h2, k + 2'h3, k};
            host.wr(8'h4E, {6'h3F, v});
            cyc(1);
            `CHK({ramp_speed, out_four_discharge_rate, out_three_discharge_rate, pair_two_discharge_rate, pair_one_discharge_rate}, v)
            rchk(8'h4E, {6'h00, v});
        end
        host.wr(8'h08, 16'hFFFF);
        cyc(1);
        `CHK(tieoff_buffer_force, 1'b1)
        rchk(8'h08, 16'h2000);
    endtask : t_pop_and_force

    task automatic t_tieoff;
        logic [3:0] en_t [4] = '{4'h3, 4'hC, 4'h0, 4'hF};
        logic [3:0] sel_t [4] = '{4'h5, 4'h5, 4'hF, 4'h0};
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h4C, {4'h0, sel_t[i], 8'hFF});
            out_enable = en_t[i];
            cyc(2);
            `CHK(tieoff_low_res_on, ~en_t[i] & ~sel_t[i])
            `CHK(tieoff_high_res_on, ~en_t[i] & sel_t[i])
            rchk(8'h4C, {4'h0, sel_t[i], 8'h00});
        end
    endtask : t_tieoff

    task automatic t_events;
        for (int i = 0; i < 4; i++) begin
            for (int p = 0; p < 2; p++) begin
                lv[i] = ~lv[i];
                cyc(3);
                `CHK(codec_first_level_irq, 1'b1)
                rchk(8'h1F, 16'h0100 << i);
                cyc(2);
                `CHK(codec_first_level_irq, 1'b0)
                rchk(8'h1F, 16'h0000);
            end
        end
        host.wr(8'h27, 16'hFFFF);
        rchk(8'h27, 16'h0F00);
        lv = ~lv;
        cyc(3);
        `CHK(codec_first_level_irq, 1'b0)
        host.wr(8'h27, 16'h0000);
        cyc(2);
        `CHK(codec_first_level_irq, 1'b1)
        rchk(8'h1F, 16'h0F00);
    endtask : t_events

    task automatic t_zero_cross;
        int n;
        gain_pending = 4'hF;
        wait_apply(10, n);
        `CHK(ap, 4'hF)
        cyc(1);
        zc_enable = 4'hF;
        zero_cross = 4'h5;
        gain_pending = 4'h5;
        wait_apply(10, n);
        `CHK(ap, 4'h5)
        zero_cross = 4'h0;
        host.slow_gate(1'b0);
        gain_pending = 4'h1;
        wait_apply(40, n);
        `CHK(n, 40)
        host.slow_gate(1'b1);
        wait_apply(60, n);
        `CHK(n >= (ZC_TIMEOUT - 1) * SLOW_DIV && n <= (ZC_TIMEOUT + 1) * SLOW_DIV + 3, 1'b1)
    endtask : t_zero_cross

    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Scenarios need well under two thousand cycles; ten times that is a hang
    initial begin
        #(20000 * 8);
        n_errors++;
        results();
    end

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        cyc(1);
        t_reset();
        t_pop_and_force();
        t_tieoff();
        t_events();
        t_zero_cross();
        results();
    end
endmodule : tb_cap_bank
